// >>> include/rtlsc_cfg.svh
/*
  Timing and width constants of the reset timer and load switch control.
  Assumes the core clock period given here and one 100 us timebase tick.
*/
`ifndef RTLSC_CFG_SVH
`define RTLSC_CFG_SVH

// ----------------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------------
`define RTLSC_CLK_NS        5
`define RTLSC_TICK_US       100
`define RTLSC_NS_PER_US     1000
`define RTLSC_CNT_W         17

// ----------------------------------------------------------------------
// Delays in microseconds
// ----------------------------------------------------------------------
`define RTLSC_OFF_QUAL_US   1000
`define RTLSC_OFF_DLY_US    7300000
`define RTLSC_OFF_ZERO_US   600
`define RTLSC_PON_DLY_US    2300000
`define RTLSC_PON_ZERO_US   4000
`define RTLSC_RST_DLY_US    7500000
`define RTLSC_RST_ZERO_US   1000
`define RTLSC_PULSE_US      400000

`endif

// >>> include/rtlsc_pkg.sv
/*
  Types shared by the reset timer and load switch control.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtlsc_pkg;

  // Sampled control inputs
  typedef struct packed {
    logic rr_n;
    logic wake;
    logic off;
    logic dsel;
  } rtlsc_in_t;

  typedef enum logic [1:0] {
    RTLSC_ST_ON     = 2'b00,
    RTLSC_ST_OFF    = 2'b01,
    RTLSC_ST_OFFDLY = 2'b10,
    RTLSC_ST_PULSE  = 2'b11
  } rtlsc_state_t;

endpackage : rtlsc_pkg

// >>> rtl/rtlsc_top.sv
/*
  Control logic of a reset timer driving a battery load switch.
  Assumes all inputs synchronous to i_core_clk; the analog switch and the
  discharge path are driven by the two outputs.
*/
// Notes on behaviour
// [R1] Delay select high: off rise held 1 ms starts 7.3 s, then switch opens.
// [R2] Reset request or wake during delayed turn-off aborts it, switch stays on.
// [R3] Delay select low: qualified off rise opens switch after 0.6 ms.
// [R4] Wake high while off closes the switch.
// [R5] Reset request low over 2.3 s while off closes the switch.
// [R6] Off to on disarms reset; a request held low starts nothing.
// [R7] Reset re-arms, counter cleared, only after request returns high.
// [R8] Armed and on, request low 7.5 s: switch off 400 ms, then on.
// [R9] Release before 7.5 s clears the counter, no pulse.
// [R10] Reset pulse off time lies in 320..480 ms, nominal 400 ms.
// [R11] Delayed turn-off interval lies in 5.8..8.8 s.
// [R12] Zero-delay mode, switch off: turn-on after about 4 ms.
// [R13] Zero-delay mode, switch on: reset pulse starts after about 1 ms.
// [R14] Output discharge enabled while the switch is off.
// [R15] Power-on reset clears all state and ends with switch on.
// [R16] Simultaneous triggers: reset request, then wake, then off; others dropped.
// [R17] Aborted turn-off needs off low then high again to restart.
// [R18] Zero-delay mode needs delay select low before request falls.
// [R19] All delays are counters on one timebase over sampled inputs.
`timescale 1ns/100ps
`default_nettype none
`include "rtlsc_cfg.svh"

module rtlsc_top
  import rtlsc_pkg::*;
#(
  parameter int TICK_CYCLES = `RTLSC_TICK_US * `RTLSC_NS_PER_US / `RTLSC_CLK_NS
)
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  // Control inputs
  input  wire logic i_reset_request_n,
  input  wire logic i_wake_input,
  input  wire logic i_off,
  input  wire logic i_delay_select,
  // Switch drive
  output var  logic o_switch_on,
  output var  logic o_discharge_en
);

  localparam int W = `RTLSC_CNT_W;
  typedef logic [W-1:0] rtlsc_cnt_t;

  // Least times round up to whole ticks
  function automatic rtlsc_cnt_t rtlsc_ticks(input int us);
    rtlsc_ticks = W'((us + `RTLSC_TICK_US - 1) / `RTLSC_TICK_US);
  endfunction : rtlsc_ticks

  localparam rtlsc_cnt_t OFF_QUAL_TK = rtlsc_ticks(`RTLSC_OFF_QUAL_US);
  localparam rtlsc_cnt_t OFF_DLY_TK  = rtlsc_ticks(`RTLSC_OFF_DLY_US);
  localparam rtlsc_cnt_t OFF_ZERO_TK = rtlsc_ticks(`RTLSC_OFF_ZERO_US);
  localparam rtlsc_cnt_t PON_DLY_TK  = rtlsc_ticks(`RTLSC_PON_DLY_US);
  localparam rtlsc_cnt_t PON_ZERO_TK = rtlsc_ticks(`RTLSC_PON_ZERO_US);
  localparam rtlsc_cnt_t RST_DLY_TK  = rtlsc_ticks(`RTLSC_RST_DLY_US);
  localparam rtlsc_cnt_t RST_ZERO_TK = rtlsc_ticks(`RTLSC_RST_ZERO_US);
  localparam rtlsc_cnt_t PULSE_TK    = rtlsc_ticks(`RTLSC_PULSE_US);
  localparam rtlsc_cnt_t CNT_ONE     = 17'h00001;
  localparam rtlsc_cnt_t CNT_MAX     = 17'h1FFFF;

  rtlsc_in_t    smp_reg;
  rtlsc_in_t    prv_reg;
  rtlsc_state_t state_reg;
  rtlsc_state_t state_next;
  logic [31:0]  tick_cnt_reg;
  logic         tick_reg;
  rtlsc_cnt_t   timer_reg;
  rtlsc_cnt_t   press_reg;
  rtlsc_cnt_t   qual_reg;
  logic         qual_act_reg;
  logic         armed_reg;
  logic         zero_lat_reg;
  logic         dly_zero_reg;
  logic         rr_fall;
  logic         wake_rise;
  logic         off_rise;
  logic         qual_done;
  rtlsc_cnt_t   dly_target;
  rtlsc_cnt_t   pon_target;
  rtlsc_cnt_t   rst_target;

  // ----------------------------------------------------------------------
  // Input sampling and edges
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      smp_reg <= '{rr_n: 1'b1, wake: 1'b0, off: 1'b0, dsel: 1'b1};
      prv_reg <= '{rr_n: 1'b1, wake: 1'b0, off: 1'b0, dsel: 1'b1};
    end
    else
    begin
      smp_reg <= '{rr_n: i_reset_request_n, wake: i_wake_input,
                   off: i_off, dsel: i_delay_select}; // [R19]
      prv_reg <= smp_reg;
    end
  end

  assign rr_fall   = prv_reg.rr_n & ~smp_reg.rr_n;
  assign wake_rise = ~prv_reg.wake & smp_reg.wake;
  assign off_rise  = ~prv_reg.off & smp_reg.off;

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg     <= 1'b1; // [R19]
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Press counter, arming and zero-delay latch
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      press_reg <= 17'h00000;
    else if (smp_reg.rr_n)
      press_reg <= 17'h00000; // [R7] [R9]
    else if (tick_reg && press_reg != CNT_MAX)
      press_reg <= press_reg + CNT_ONE;
  end

  // Disarm wins over re-arm so a switch-on with the button released
  // still needs one high sample afterwards.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      armed_reg <= 1'b0;
    else if (state_next == RTLSC_ST_ON && state_reg != RTLSC_ST_ON &&
             state_reg != RTLSC_ST_OFFDLY)
      armed_reg <= 1'b0; // [R6]
    else if (smp_reg.rr_n)
      armed_reg <= 1'b1; // [R7]
  end

  // Delay select is judged from the sample before the request fell
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      zero_lat_reg <= 1'b0;
    else if (rr_fall)
      zero_lat_reg <= ~prv_reg.dsel; // [R18]
  end

  assign pon_target = zero_lat_reg ? PON_ZERO_TK : PON_DLY_TK; // [R12]
  assign rst_target = zero_lat_reg ? RST_ZERO_TK : RST_DLY_TK; // [R13]
  assign dly_target = dly_zero_reg ? OFF_ZERO_TK : OFF_DLY_TK;

  // ----------------------------------------------------------------------
  // Off qualification: level held 1 ms after a clean rise
  // ----------------------------------------------------------------------
  assign qual_done = qual_act_reg && tick_reg && qual_reg == OFF_QUAL_TK;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      qual_act_reg <= 1'b0;
      qual_reg     <= 17'h00000;
    end
    else if (state_reg != RTLSC_ST_ON || !smp_reg.off || qual_done)
    begin
      qual_act_reg <= 1'b0; // [R17]
      qual_reg     <= 17'h00000;
    end
    else if (off_rise && !rr_fall && !wake_rise)
    begin
      qual_act_reg <= 1'b1; // [R16]
      qual_reg     <= 17'h00000;
    end
    else if (qual_act_reg && tick_reg)
      qual_reg <= qual_reg + CNT_ONE; // [R1]
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      dly_zero_reg <= 1'b0;
    else if (qual_done)
      dly_zero_reg <= ~smp_reg.dsel; // [R3]
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RTLSC_ST_OFF:
        if (smp_reg.wake)
          state_next = RTLSC_ST_ON; // [R4]
        else if (!smp_reg.rr_n && press_reg >= pon_target)
          state_next = RTLSC_ST_ON; // [R5] [R12]
      RTLSC_ST_ON:
        if (armed_reg && !smp_reg.rr_n && press_reg >= rst_target)
          state_next = RTLSC_ST_PULSE; // [R8] [R13] [R16]
        else if (qual_done)
          state_next = RTLSC_ST_OFFDLY; // [R1] [R3]
      RTLSC_ST_OFFDLY:
        if (rr_fall || wake_rise)
          state_next = RTLSC_ST_ON; // [R2]
        else if (tick_reg && timer_reg == dly_target - CNT_ONE)
          state_next = RTLSC_ST_OFF; // [R1] [R11]
      RTLSC_ST_PULSE:
        if (tick_reg && timer_reg == PULSE_TK - CNT_ONE)
          state_next = RTLSC_ST_ON; // [R8] [R10]
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      state_reg <= RTLSC_ST_ON; // [R15]
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      timer_reg <= 17'h00000;
    else if (state_next != state_reg)
      timer_reg <= 17'h00000;
    else if (tick_reg)
      timer_reg <= timer_reg + CNT_ONE; // [R19]
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_switch_on    <= 1'b1; // [R15]
      o_discharge_en <= 1'b0;
    end
    else
    begin
      o_switch_on    <= state_next == RTLSC_ST_ON || state_next == RTLSC_ST_OFFDLY;
      o_discharge_en <= state_next == RTLSC_ST_OFF || state_next == RTLSC_ST_PULSE; // [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence rtlsc_qual_s;
    qual_done && state_reg == RTLSC_ST_ON && !(armed_reg && !smp_reg.rr_n &&
      press_reg >= rst_target);
  endsequence

  sequence rtlsc_enter_dly_s;
    ##1 state_reg == RTLSC_ST_OFFDLY && timer_reg == 17'h00000;
  endsequence

  off_delay_end_a: assert property (state_reg == RTLSC_ST_OFFDLY &&
    state_next == RTLSC_ST_OFF |-> dly_zero_reg || timer_reg == OFF_DLY_TK - CNT_ONE) // [R1]
    else $error("delayed turn-off ended at wrong count");
  off_start_a: assert property (rtlsc_qual_s |-> rtlsc_enter_dly_s ##0 o_switch_on) // [R1] [R3]
    else $error("qualified off did not start the turn-off delay");
  off_abort_a: assert property (state_reg == RTLSC_ST_OFFDLY && rr_fall |=>
    state_reg == RTLSC_ST_ON && o_switch_on) // [R2]
    else $error("turn-off not aborted by reset request");
  zero_off_a: assert property (state_reg == RTLSC_ST_OFFDLY && state_next == RTLSC_ST_OFF &&
    dly_zero_reg |-> timer_reg == OFF_ZERO_TK - CNT_ONE) // [R3]
    else $error("zero turn-off at wrong count");
  wake_on_a: assert property (state_reg == RTLSC_ST_OFF && smp_reg.wake |=>
    o_switch_on && !o_discharge_en) // [R4]
    else $error("wake did not close the switch");
  hold_on_a: assert property (state_reg == RTLSC_ST_OFF && state_next == RTLSC_ST_ON &&
    !smp_reg.wake |-> press_reg >= pon_target) // [R5]
    else $error("switch closed before hold time");
  disarm_a: assert property ($rose(o_switch_on) |-> !armed_reg) // [R6]
    else $error("reset still armed after switch-on");
  rearm_a: assert property ($rose(armed_reg) |-> $past(smp_reg.rr_n) && press_reg == 17'h00000) // [R7]
    else $error("re-armed without release");
  pulse_start_a: assert property (state_reg == RTLSC_ST_ON && state_next == RTLSC_ST_PULSE
    |-> armed_reg && press_reg >= rst_target ##1 !o_switch_on) // [R8]
    else $error("reset pulse started without armed long press");
  no_pulse_a: assert property (smp_reg.rr_n |=> press_reg == 17'h00000 ##1
    state_reg != RTLSC_ST_PULSE || $past(state_reg) == RTLSC_ST_PULSE) // [R9]
    else $error("press counter not cleared on release");
  pulse_len_a: assert property (state_reg == RTLSC_ST_PULSE && state_next != RTLSC_ST_PULSE
    |-> tick_reg && timer_reg == PULSE_TK - CNT_ONE) // [R10]
    else $error("reset pulse length wrong");
  discharge_a: assert property (o_discharge_en == !o_switch_on) // [R14]
    else $error("discharge not opposite to switch");
  prio_a: assert property (state_reg == RTLSC_ST_ON && off_rise && (rr_fall || wake_rise)
    |=> !qual_act_reg) // [R16]
    else $error("lower priority off not dropped");

endmodule : rtlsc_top

`default_nettype wire

// >>> verification/rtlsc_partner.sv
/*
  Far side model: push button, wake source and off request of the host.
  Assumes the bench calls apply() from its main process, once at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module rtlsc_partner
  import rtlsc_pkg::*;
(
  // Clock
  input  wire logic      i_core_clk,
  // Input pins of the control block
  output var  rtlsc_in_t o_pins
);
  // ----------------------------------------------------------------------
  // Pin levels, changed just after a rising edge
  // ----------------------------------------------------------------------
  // Last requested levels; o_pins may still have an update pending in this step
  rtlsc_in_t last_v = '{rr_n: 1'b1, wake: 1'b0, off: 1'b0, dsel: 1'b1};

  initial o_pins = '{rr_n: 1'b1, wake: 1'b0, off: 1'b0, dsel: 1'b1};

  task automatic apply(input rtlsc_in_t v);
    // Delay select settles one edge ahead of a falling request
    if (v.rr_n == 1'b0 && last_v.rr_n == 1'b1 && v.dsel != last_v.dsel)
    begin
      @(posedge i_core_clk);
      o_pins.dsel <= v.dsel;
    end
    // Levels are held until the next call; an off rise needs off low first
    @(posedge i_core_clk);
    o_pins <= v;
    last_v = v;
  endtask : apply
endmodule : rtlsc_partner

`default_nettype wire

// >>> verification/test_reset_timer_load_switch_control.sv
/*
  Self-checking bench of the reset timer and load switch control.
  Assumes a 4-clock timebase tick so that the 400 ms pulse fits the run.
*/
`timescale 1ns/100ps
`default_nettype none

`define RTLSC_CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module test_reset_timer_load_switch_control;
  import rtlsc_pkg::*;
  // Long delays stay out of reach; only the zero-delay paths are timed
  localparam int TICK  = 4;
  localparam int LIMIT = 40000;

  logic      i_core_clk;
  logic      i_rstn;
  rtlsc_in_t pins;
  logic      o_switch_on;
  logic      o_discharge_en;
  int        mismatches;
  int        samples_checked;
  int        cycles;
  int        n;

  // ----------------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  rtlsc_partner p (
    .i_core_clk (i_core_clk),
    .o_pins     (pins)
  );

  rtlsc_top #(.TICK_CYCLES(TICK)) dut (
    .i_core_clk        (i_core_clk),
    .i_rstn            (i_rstn),
    .i_reset_request_n (pins.rr_n),
    .i_wake_input      (pins.wake),
    .i_off             (pins.off),
    .i_delay_select    (pins.dsel),
    .o_switch_on       (o_switch_on),
    .o_discharge_en    (o_discharge_en)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic set(input logic rr_n, wake, off, dsel);
    p.apply('{rr_n, wake, off, dsel});
  endtask : set

  task automatic idle(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask : idle

  // Cycles until the switch shows val, bounded by lim
  task automatic wait_sw(input logic val, input int lim, output int cnt);
    cnt = 0;
    while (o_switch_on !== val && cnt < lim)
    begin
      @(posedge i_core_clk);
      #1;
      cnt++;
    end
  endtask : wait_sw

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_por();
    idle(2);
    `RTLSC_CHK("por_on", 1'b1, o_switch_on);
    `RTLSC_CHK("por_discharge", 1'b0, o_discharge_en);
    set(1, 0, 0, 0);
  endtask : t_por

  task automatic t_zero_off();
    set(1, 0, 1, 0);
    wait_sw(1'b0, 40 * TICK, n);
    `RTLSC_CHK("off_delay", 1'b1, n >= 15 * TICK - 2 && n <= 17 * TICK + 4);
    `RTLSC_CHK("discharge_off", 1'b1, o_discharge_en);
    set(1, 0, 0, 0);
  endtask : t_zero_off

  task automatic t_wake_prio();
    set(1, 1, 0, 0);
    wait_sw(1'b1, 20, n);
    `RTLSC_CHK("wake_on", 1'b1, n <= 3);
    `RTLSC_CHK("discharge_on", 1'b0, o_discharge_en);
    set(1, 0, 0, 0);
    set(1, 1, 1, 0);
    idle(40 * TICK);
    `RTLSC_CHK("prio_off_dropped", 1'b1, o_switch_on);
    set(1, 0, 0, 0);
  endtask : t_wake_prio

  task automatic t_abort();
    set(1, 0, 1, 0);
    idle(51);
    set(1, 1, 1, 0);
    idle(100 * TICK);
    `RTLSC_CHK("abort_on", 1'b1, o_switch_on);
    set(1, 0, 1, 0);
    idle(30 * TICK);
    `RTLSC_CHK("held_off_no_retrig", 1'b1, o_switch_on);
    set(1, 0, 0, 0);
  endtask : t_abort

  task automatic t_zero_reset();
    set(0, 0, 0, 0);
    wait_sw(1'b1, 60 * TICK, n);
    `RTLSC_CHK("hold_on_delay", 1'b1, n >= 39 * TICK - 2 && n <= 40 * TICK + 4);
    idle(40 * TICK);
    `RTLSC_CHK("disarmed_on", 1'b1, o_switch_on);
    set(1, 0, 0, 0);
    idle(4);
    set(0, 0, 0, 0);
    wait_sw(1'b0, 20 * TICK, n);
    `RTLSC_CHK("pulse_start", 1'b1, n >= 9 * TICK - 2 && n <= 10 * TICK + 4);
    wait_sw(1'b1, 4100 * TICK, n);
    `RTLSC_CHK("pulse_len", 1'b1, n >= 4000 * TICK - 2 && n <= 4000 * TICK + 2);
    idle(20 * TICK);
    `RTLSC_CHK("after_pulse_on", 1'b1, o_switch_on);
    set(1, 0, 0, 0);
  endtask : t_zero_reset

  // The long turn-off is cut by a request fall; the next zero-delay off
  // would stay on if the delay were still pending
  task automatic t_long();
    set(1, 0, 0, 1);
    set(0, 0, 0, 1);
    idle(100 * TICK);
    `RTLSC_CHK("long_press_on", 1'b1, o_switch_on);
    set(1, 0, 0, 1);
    idle(100 * TICK);
    `RTLSC_CHK("release_no_pulse", 1'b1, o_switch_on);
    set(1, 0, 1, 1);
    idle(100 * TICK);
    `RTLSC_CHK("long_off_pending", 1'b1, o_switch_on);
    set(0, 0, 1, 1);
    idle(8);
    `RTLSC_CHK("abort_by_request", 1'b1, o_switch_on);
    set(1, 0, 0, 1);
  endtask : t_long

  task automatic t_mid_reset();
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    idle(2);
    `RTLSC_CHK("mid_reset_on", 1'b1, o_switch_on);
    `RTLSC_CHK("mid_reset_discharge", 1'b0, o_discharge_en);
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    idle(2);
    `RTLSC_CHK("released_on", 1'b1, o_switch_on);
    t_zero_off();
  endtask : t_mid_reset

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    mismatches      = 0;
    samples_checked = 0;
    cycles          = 0;
    i_rstn          = 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    t_por();
    t_zero_off();
    t_wake_prio();
    t_abort();
    t_zero_off();
    t_zero_reset();
    t_long();
    t_zero_off();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : test_reset_timer_load_switch_control

`default_nettype wire
